/* common/hswc_pkg.sv */
package hswc_pkg;
  localparam int OPND_W = 8;
  localparam int NUM_SRC = 7;
  // source numbering, shared by release requests and interrupt enables
  localparam int SRC_PORT = 0;
  localparam int SRC_TIMER_ONE = 1;
  localparam int SRC_PIN = 2;
  localparam int SRC_PREDIV = 3;
  localparam int SRC_TIMER_TWO = 4;
  localparam int SRC_KEY = 5;
  localparam int SRC_FREQ = 6;
  // operand bit positions
  localparam int WAKE_EN_BIT = 4;
  localparam int HALT_EN_LSB = 1;
  localparam int HALT_EN_MSB = 6;
  localparam int STOP_KEY_BIT = 7;
  localparam int STOP_PIN_BIT = 5;
  localparam int STOP_PORT_BIT = 4;
  // status nibble positions
  localparam int STC_PIN = 0;
  localparam int STC_TIMER_ONE = 1;
  localparam int STC_STAGE = 2;
  localparam int STC_PREDIV = 3;
  localparam int STX_KEY = 0;
  localparam int STX_TIMER_TWO = 1;
  localparam int STX_FREQ = 3;
  // reset values
  localparam logic RST_WAKE_EN = 1'b0;
  localparam logic [5:0] RST_HALT_EN = 6'h00;
  localparam logic [6:0] RST_IRQ_EN = 7'h00;
  localparam logic [2:0] RST_STOP_EN = 3'h0;
  localparam logic [6:0] RST_REQ = 7'h00;
  typedef enum logic [2:0] {
    MODE_RUN = 3'b001,
    MODE_HALT = 3'b010,
    MODE_STOP = 3'b100
  } hswc_mode_type;
endpackage

/* rtl/hswc_core.sv */
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - port wake enable is write-only bit 4
// - enabled port change releases halt, sets flag
// - port high level releases stop when enabled
// - every stop release passes into halt
// - unconfirmed port level returns to stop
// - port flag sets request zero, maybe irq
// - port irq inhibited after accept until reconfig
// - six halt release enables per source
// - enabled source event releases halt
// - pin change releases stop when enabled
// - key level releases stop when enabled
// - seven interrupt enables per source
// - accept clears request and interrupt enable
// - three stop release enables bits 7,5,4
// - operand bit n maps to flag n
// - halt stops fetch, keeps clocks running
// - halt refused while release signal pending
// - accept ends halt, return re-enters halt, or stop after a port-level stop exit
// - start flags clear with request or enable
module hswc_core #(
  parameter int NUM_PORT = 4,
  parameter int NUM_KEY = 4
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [hswc_pkg::OPND_W-1:0] operand_in,
  input wire logic port_wake_config_instr_in,
  input wire logic halt_enable_instr_in,
  input wire logic irq_enable_instr_in,
  input wire logic stop_release_instr_in,
  input wire logic release_clear_instr_in,
  input wire logic halt_instr_in,
  input wire logic stop_instr_in,
  input wire logic return_instr_in,
  input wire logic irq_ack_in,
  input wire logic [2:0] irq_ack_id_in,
  input wire logic [NUM_PORT-1:0] port_level_in,
  input wire logic port_change_in,
  input wire logic timer1_uflow_in,
  input wire logic pin_edge_in,
  input wire logic prediv_ovf_in,
  input wire logic prediv_stage15_in,
  input wire logic timer2_uflow_in,
  input wire logic [NUM_KEY-1:0] key_latched_in,
  input wire logic freqcnt_stop_in,
  output logic [6:0] irq_req_out,
  output logic [6:0] release_req_out,
  output logic port_start_cond_flag_out,
  output logic aux_start_cond_flag_out,
  output logic [3:0] status_c_out,
  output logic [3:0] status_x_out,
  output logic halt_mode_out,
  output logic stop_mode_out,
  output logic fetch_stop_out
);

  if (NUM_PORT < 1 || NUM_KEY < 1) begin : g_chk
    $error("hswc_core needs at least one port and one key input");
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  logic port_change_wake_en_r;
  logic [5:0] halt_en_r;
  logic [6:0] irq_en_r;
  logic [2:0] stop_en_r;
  logic port_irq_inhibit_r;
  logic [6:0] req_r;
  logic [6:0] req_set;
  logic [6:0] req_clr;
  logic [6:0] ack_onehot;
  logic [6:0] src_event;
  logic port_start_r;
  logic port_start_set;
  logic [3:0] status_c_r;
  logic [3:0] status_x_r;
  hswc_pkg::hswc_mode_type mode_r;
  hswc_pkg::hswc_mode_type resume_r;
  logic svc_active_r;
  logic from_port_stop_r;
  logic [6:1] gated_req;
  logic halt_pend;
  logic stop_port_cond;
  logic stop_pin_cond;
  logic stop_key_cond;
  logic stop_wake;
  logic key_or;

  assign key_or = |key_latched_in;
  assign ack_onehot = irq_ack_in ? 7'(8'h01 << irq_ack_id_in) : 7'h00;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      port_change_wake_en_r <= hswc_pkg::RST_WAKE_EN;
    end else if (port_wake_config_instr_in) begin
      port_change_wake_en_r <= operand_in[hswc_pkg::WAKE_EN_BIT];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      halt_en_r <= hswc_pkg::RST_HALT_EN;
    end else if (halt_enable_instr_in) begin
      halt_en_r <= operand_in[hswc_pkg::HALT_EN_MSB:hswc_pkg::HALT_EN_LSB];
    end
  end

  // software write wins over acceptance only when both land together
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      irq_en_r <= hswc_pkg::RST_IRQ_EN;
    end else if (irq_enable_instr_in) begin
      irq_en_r <= operand_in[6:0];
    end else begin
      irq_en_r <= irq_en_r & ~ack_onehot;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      stop_en_r <= hswc_pkg::RST_STOP_EN;
    end else if (stop_release_instr_in) begin
      stop_en_r <= {operand_in[hswc_pkg::STOP_KEY_BIT], operand_in[hswc_pkg::STOP_PIN_BIT],
                    operand_in[hswc_pkg::STOP_PORT_BIT]};
    end
  end

  // acceptance of port irq blocks further ones until reconfigured
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      port_irq_inhibit_r <= 1'b0;
    end else if (ack_onehot[hswc_pkg::SRC_PORT]) begin
      port_irq_inhibit_r <= 1'b1;
    end else if (port_wake_config_instr_in) begin
      port_irq_inhibit_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // start condition and release requests

  assign port_start_set = port_change_wake_en_r & port_change_in;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      port_start_r <= 1'b0;
    end else if (port_start_set) begin
      port_start_r <= 1'b1;
    end else if ((release_clear_instr_in && operand_in[hswc_pkg::SRC_PORT])
                 || (port_wake_config_instr_in && !operand_in[hswc_pkg::WAKE_EN_BIT])) begin
      port_start_r <= 1'b0;
    end
  end

  always_comb begin
    src_event = 7'h00;
    src_event[hswc_pkg::SRC_PORT] = port_start_set;
    src_event[hswc_pkg::SRC_TIMER_ONE] = timer1_uflow_in;
    src_event[hswc_pkg::SRC_PIN] = pin_edge_in;
    src_event[hswc_pkg::SRC_PREDIV] = prediv_ovf_in;
    src_event[hswc_pkg::SRC_TIMER_TWO] = timer2_uflow_in;
    src_event[hswc_pkg::SRC_KEY] = key_or;
    src_event[hswc_pkg::SRC_FREQ] = freqcnt_stop_in;
  end

  assign req_set = src_event;
  assign req_clr = (release_clear_instr_in ? operand_in[6:0] : 7'h00) | ack_onehot;

  // set beats clear so no wake event is dropped
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      req_r <= hswc_pkg::RST_REQ;
    end else begin
      req_r <= (req_r & ~req_clr) | req_set;
    end
  end

  assign gated_req = req_r[6:1] & halt_en_r;

  // flags follow request and enable, so either clear drops them
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      status_c_r <= 4'h0;
      status_x_r <= 4'h0;
    end else begin
      status_c_r[hswc_pkg::STC_PIN] <= gated_req[hswc_pkg::SRC_PIN];
      status_c_r[hswc_pkg::STC_TIMER_ONE] <= gated_req[hswc_pkg::SRC_TIMER_ONE];
      status_c_r[hswc_pkg::STC_STAGE] <= prediv_stage15_in;
      status_c_r[hswc_pkg::STC_PREDIV] <= gated_req[hswc_pkg::SRC_PREDIV];
      status_x_r[hswc_pkg::STX_KEY] <= gated_req[hswc_pkg::SRC_KEY];
      status_x_r[hswc_pkg::STX_TIMER_TWO] <= gated_req[hswc_pkg::SRC_TIMER_TWO];
      status_x_r[2] <= 1'b0;
      status_x_r[hswc_pkg::STX_FREQ] <= gated_req[hswc_pkg::SRC_FREQ];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // halt / stop sequencing

  assign halt_pend = port_start_r | (|gated_req);
  assign stop_port_cond = stop_en_r[0] & port_change_wake_en_r & (|port_level_in);
  assign stop_pin_cond = stop_en_r[1] & halt_en_r[hswc_pkg::SRC_PIN - 1] & pin_edge_in;
  assign stop_key_cond = stop_en_r[2] & halt_en_r[hswc_pkg::SRC_KEY - 1] & key_or;
  assign stop_wake = stop_port_cond | stop_pin_cond | stop_key_cond;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      mode_r <= hswc_pkg::MODE_RUN;
    end else begin
      case (mode_r)
        hswc_pkg::MODE_RUN: begin
          if (stop_instr_in) begin
            mode_r <= (stop_wake || halt_pend) ? hswc_pkg::MODE_HALT : hswc_pkg::MODE_STOP;
          end else if (halt_instr_in && !halt_pend) begin
            mode_r <= hswc_pkg::MODE_HALT;
          end else if (return_instr_in && svc_active_r) begin
            mode_r <= resume_r;
          end
        end
        hswc_pkg::MODE_HALT: begin
          if (irq_ack_in || halt_pend) begin
            mode_r <= hswc_pkg::MODE_RUN;
          end else if (from_port_stop_r && !(|port_level_in)) begin
            mode_r <= hswc_pkg::MODE_STOP;
          end
        end
        hswc_pkg::MODE_STOP: begin
          if (stop_wake) begin
            mode_r <= hswc_pkg::MODE_HALT;
          end
        end
        default: begin
          mode_r <= hswc_pkg::MODE_RUN;
        end
      endcase
    end
  end

  // remembers a stop exit caused only by the raw port level
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      from_port_stop_r <= 1'b0;
    end else if (mode_r == hswc_pkg::MODE_STOP) begin
      from_port_stop_r <= stop_port_cond & ~stop_pin_cond & ~stop_key_cond;
    end else if (mode_r != hswc_pkg::MODE_HALT || halt_pend || irq_ack_in) begin
      from_port_stop_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      svc_active_r <= 1'b0;
      resume_r <= hswc_pkg::MODE_RUN;
    end else if (irq_ack_in) begin
      svc_active_r <= 1'b1;
      if (mode_r == hswc_pkg::MODE_HALT) begin
        resume_r <= from_port_stop_r ? hswc_pkg::MODE_STOP : hswc_pkg::MODE_HALT;
      end else begin
        resume_r <= hswc_pkg::MODE_RUN;
      end
    end else if (return_instr_in && mode_r == hswc_pkg::MODE_RUN) begin
      svc_active_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  always_comb begin
    irq_req_out = req_r & irq_en_r;
    irq_req_out[hswc_pkg::SRC_PORT] = req_r[hswc_pkg::SRC_PORT] & irq_en_r[hswc_pkg::SRC_PORT]
                                      & ~port_irq_inhibit_r;
  end

  assign release_req_out = req_r;
  assign port_start_cond_flag_out = port_start_r;
  assign aux_start_cond_flag_out = |gated_req;
  assign status_c_out = status_c_r;
  assign status_x_out = status_x_r;
  assign halt_mode_out = mode_r == hswc_pkg::MODE_HALT;
  assign stop_mode_out = mode_r == hswc_pkg::MODE_STOP;
  assign fetch_stop_out = mode_r != hswc_pkg::MODE_RUN;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_WAKE_WRITE: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    port_wake_config_instr_in |=> port_change_wake_en_r == $past(operand_in[4]))
    else $error("wake enable not taken from operand bit 4");

  AST_PORT_FLAG: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (port_change_wake_en_r && port_change_in) |=> port_start_r && req_r[0])
    else $error("port change did not raise start flag");

  AST_STOP_EXIT: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (mode_r == hswc_pkg::MODE_STOP && stop_wake) |=> mode_r == hswc_pkg::MODE_HALT)
    else $error("stop release did not pass into halt");

  AST_PORT_INHIBIT: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (irq_ack_in && irq_ack_id_in == 3'h0 && !port_wake_config_instr_in) |=> !irq_req_out[0])
    else $error("port irq raised while inhibited");

  AST_ACK_CLEAR: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (irq_ack_in && irq_ack_id_in == 3'h5 && !irq_enable_instr_in && !key_or)
    |=> !irq_en_r[5] && !req_r[5])
    else $error("accepted key irq not cleared");

  AST_HALT_REFUSED: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (mode_r == hswc_pkg::MODE_RUN && halt_instr_in && halt_pend && !stop_instr_in)
    |=> mode_r == hswc_pkg::MODE_RUN)
    else $error("halt entered with release pending");

  AST_HALT_ACK: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (mode_r == hswc_pkg::MODE_HALT && irq_ack_in) |=> mode_r == hswc_pkg::MODE_RUN ##0 svc_active_r)
    else $error("accepted irq did not end halt");

  AST_RETURN_HALT: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (mode_r == hswc_pkg::MODE_HALT && irq_ack_in && !from_port_stop_r)
    ##1 (return_instr_in && !stop_instr_in && !halt_instr_in) |=> mode_r == hswc_pkg::MODE_HALT)
    else $error("return did not re-enter halt");

  AST_FLAG_CLEAR: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (release_clear_instr_in && operand_in[1] && !timer1_uflow_in) |=> ##1 !status_c_out[1])
    else $error("timer one start flag survived request clear");

  AST_HALT_WAKE: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (mode_r == hswc_pkg::MODE_HALT && halt_en_r[0] && timer1_uflow_in) |-> ##[1:2] mode_r == hswc_pkg::MODE_RUN)
    else $error("enabled timer one event did not end halt");

  COV_STOP_PORT: cover property (@(posedge core_clk_in) disable iff (sys_rst_in)
    mode_r == hswc_pkg::MODE_STOP ##1 mode_r == hswc_pkg::MODE_HALT ##[1:20] mode_r == hswc_pkg::MODE_STOP);
  COV_HALT_IRQ: cover property (@(posedge core_clk_in) disable iff (sys_rst_in)
    mode_r == hswc_pkg::MODE_HALT && irq_ack_in);
  COV_HALT_WAKE: cover property (@(posedge core_clk_in) disable iff (sys_rst_in)
    mode_r == hswc_pkg::MODE_HALT && halt_pend && !irq_ack_in);

endmodule
`default_nettype wire

/* testbench/hswc_seq_model.sv */
`timescale 1ns/100ps
`default_nettype none
module hswc_seq_model (
  input wire logic core_clk_in,
  output logic [7:0] operand_out,
  output logic [7:0] strobe_out,
  output logic irq_ack_out,
  output logic [2:0] irq_ack_id_out
);
  initial begin
    operand_out = 8'h00;
    strobe_out = 8'h00;
    irq_ack_out = 1'b0;
    irq_ack_id_out = 3'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one instruction per call, gap idles the sequencer first
  task automatic exec(input int kind, input logic [7:0] op, input int gap);
    repeat (gap) @(posedge core_clk_in);
    @(posedge core_clk_in);
    strobe_out[kind] <= 1'b1;
    operand_out <= op;
    @(posedge core_clk_in);
    strobe_out[kind] <= 1'b0;
    #1;
  endtask
  // acceptance of one interrupt, service routine re-arms enables itself
  task automatic ack(input logic [2:0] id);
    @(posedge core_clk_in);
    irq_ack_out <= 1'b1;
    irq_ack_id_out <= id;
    @(posedge core_clk_in);
    irq_ack_out <= 1'b0;
    #1;
  endtask
endmodule
`default_nettype wire

/* testbench/test_halt_stop_wake_control.sv */
`timescale 1ns/100ps
`default_nettype none
module test_halt_stop_wake_control;
  localparam int K_WAKE = 0;
  localparam int K_HEN = 1;
  localparam int K_IEN = 2;
  localparam int K_SREL = 3;
  localparam int K_CLR = 4;
  localparam int K_HALT = 5;
  localparam int K_STOP = 6;
  localparam int K_RET = 7;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] opnd;
  logic [7:0] strb;
  logic ack_v;
  logic [2:0] ack_id;
  logic [6:0] ev = 7'h00;
  logic [3:0] plvl = 4'h0;
  logic [3:0] keys = 4'h0;
  logic [6:0] irq_req;
  logic [6:0] rel_req;
  logic port_flag;
  logic aux_flag;
  logic halt_m;
  logic stop_m;
  logic fetch_stop;
  logic [3:0] stc;
  logic [3:0] stx;
  int err_total = 0;
  int total_checks = 0;
  always #10 clk = ~clk;
  hswc_seq_model i_hswc_seq_model (.core_clk_in(clk), .operand_out(opnd), .strobe_out(strb),
    .irq_ack_out(ack_v), .irq_ack_id_out(ack_id));
  hswc_core i_hswc_core (.core_clk_in(clk), .sys_rst_in(rst), .operand_in(opnd),
    .port_wake_config_instr_in(strb[K_WAKE]), .halt_enable_instr_in(strb[K_HEN]),
    .irq_enable_instr_in(strb[K_IEN]), .stop_release_instr_in(strb[K_SREL]),
    .release_clear_instr_in(strb[K_CLR]), .halt_instr_in(strb[K_HALT]), .stop_instr_in(strb[K_STOP]),
    .return_instr_in(strb[K_RET]), .irq_ack_in(ack_v), .irq_ack_id_in(ack_id), .port_level_in(plvl),
    .port_change_in(ev[0]), .timer1_uflow_in(ev[1]), .pin_edge_in(ev[2]), .prediv_ovf_in(ev[3]),
    .prediv_stage15_in(1'b0), .timer2_uflow_in(ev[4]), .key_latched_in(keys), .freqcnt_stop_in(ev[6]),
    .irq_req_out(irq_req), .release_req_out(rel_req), .port_start_cond_flag_out(port_flag),
    .aux_start_cond_flag_out(aux_flag), .status_c_out(stc), .status_x_out(stx), .halt_mode_out(halt_m),
    .stop_mode_out(stop_m), .fetch_stop_out(fetch_stop));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic ex(input int k, input logic [7:0] op);
    i_hswc_seq_model.exec(k, op, 0);
  endtask
  // source 5 is the key latch level, the rest are event pulses
  task automatic src_pulse(input int n);
    @(posedge clk);
    if (n == 5) keys <= 4'h4;
    else ev[n] <= 1'b1;
    @(posedge clk);
    keys <= 4'h0;
    ev <= 7'h00;
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // expected {status_x, status_c} after a wake by source n
  function automatic logic [7:0] st_exp(input int n);
    logic [7:0] v;
    v = 8'h00;
    case (n)
      1: v[hswc_pkg::STC_TIMER_ONE] = 1'b1;
      2: v[hswc_pkg::STC_PIN] = 1'b1;
      3: v[hswc_pkg::STC_PREDIV] = 1'b1;
      4: v[4 + hswc_pkg::STX_TIMER_TWO] = 1'b1;
      5: v[4 + hswc_pkg::STX_KEY] = 1'b1;
      default: v[4 + hswc_pkg::STX_FREQ] = 1'b1;
    endcase
    return v;
  endfunction
  task automatic wrap_up;
    if (err_total == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    step(1);
    chk({irq_req, port_flag}, 8'h00);
    chk({rel_req, aux_flag}, 8'h00);
    chk({halt_m, stop_m, fetch_stop}, 8'h00);
    for (int n = 1; n <= 6; n++) begin
      ex(K_HEN, 8'h01 << n);
      i_hswc_seq_model.exec(K_IEN, 8'h01 << n, n % 3);
      ex(K_HALT, 8'h00);
      chk(halt_m, 8'h01);
      chk(fetch_stop, 8'h01);
      src_pulse(n);
      chk(rel_req, 8'h01 << n);
      chk(irq_req, 8'h01 << n);
      step(1);
      chk(halt_m, 8'h00);
      chk(aux_flag, 8'h01);
      chk({stx, stc}, st_exp(n));
      ex(K_CLR, 8'h01 << n);
      chk({aux_flag, rel_req}, 8'h00);
      step(1);
      chk({stx, stc}, 8'h00);
    end
    // key interrupt accepted clears its request and enable
    ex(K_IEN, 8'h20);
    src_pulse(5);
    chk(irq_req, 8'h20);
    i_hswc_seq_model.ack(3'h5);
    chk({irq_req, rel_req}, 16'h0000);
    ex(K_IEN, 8'h00);
    ex(K_HEN, 8'h02);
    src_pulse(1);
    ex(K_HALT, 8'h00);
    chk(halt_m, 8'h00);
    ex(K_HEN, 8'h00);
    chk({aux_flag, rel_req}, 8'h02);
    ex(K_CLR, 8'h7f);
    // interrupt ends halt, return re-enters it
    ex(K_IEN, 8'h02);
    ex(K_HALT, 8'h00);
    src_pulse(1);
    chk({halt_m, irq_req}, 8'h82);
    i_hswc_seq_model.ack(3'h1);
    step(1);
    chk({halt_m, rel_req}, 8'h00);
    ex(K_RET, 8'h00);
    chk(halt_m, 8'h01);
    src_pulse(1);
    chk({irq_req, rel_req}, 8'h02);
    ex(K_HEN, 8'h02);
    step(1);
    chk(halt_m, 8'h00);
    // port change wake and interrupt inhibit
    ex(K_CLR, 8'h7f);
    ex(K_WAKE, 8'h10);
    ex(K_IEN, 8'h01);
    ex(K_HALT, 8'h00);
    src_pulse(0);
    step(1);
    chk({halt_m, port_flag, rel_req}, 16'h0081);
    chk(irq_req, 8'h01);
    i_hswc_seq_model.ack(3'h0);
    chk({irq_req, rel_req[0]}, 8'h00);
    ex(K_IEN, 8'h01);
    src_pulse(0);
    chk({irq_req, rel_req[0]}, 8'h01);
    ex(K_WAKE, 8'h10);
    chk(irq_req, 8'h01);
    // stop release by port level, pin edge and key level
    ex(K_CLR, 8'h7f);
    ex(K_IEN, 8'h00);
    ex(K_HEN, 8'h24);
    ex(K_SREL, 8'hb0);
    step(3);
    ex(K_STOP, 8'h00);
    chk({halt_m, stop_m}, 8'h01);
    @(posedge clk);
    plvl <= 4'h2;
    step(2);
    chk({halt_m, stop_m}, 8'h02);
    @(posedge clk);
    plvl <= 4'h0;
    step(2);
    chk({halt_m, stop_m}, 8'h01);
    @(posedge clk);
    plvl <= 4'h1;
    step(2);
    src_pulse(0);
    step(1);
    chk({port_flag, halt_m, stop_m}, 8'h04);
    @(posedge clk);
    plvl <= 4'h0;
    ex(K_CLR, 8'h7f);
    step(2);
    ex(K_STOP, 8'h00);
    src_pulse(2);
    chk({halt_m, stop_m}, 8'h02);
    step(1);
    chk(halt_m, 8'h00);
    ex(K_CLR, 8'h7f);
    step(2);
    ex(K_STOP, 8'h00);
    @(posedge clk);
    keys <= 4'h8;
    step(1);
    chk({halt_m, stop_m}, 8'h02);
    @(posedge clk);
    keys <= 4'h0;
    ex(K_CLR, 8'h7f);
    wrap_up();
  end
endmodule
`default_nettype wire
